// [hw/serializer_cfg_params.svh]
`ifndef SERIALIZER_CFG_PARAMS_SVH
`define SERIALIZER_CFG_PARAMS_SVH

// Register offsets
`define CFG_ADDR_GENERAL 8'h03
`define CFG_ADDR_MODE 8'h04

// Reset values
`define CFG_GENERAL_RESET 8'hD2
`define CFG_MODE_RESET 8'h80

// Writable bit masks
`define CFG_GENERAL_MASK 8'hBA
`define CFG_MODE_MASK 8'hA0

// General configuration field positions
`define CFG_BIT_CRC_CHECK 7
`define CFG_BIT_AUTO_ACK 5
`define CFG_BIT_FILTER 4
`define CFG_BIT_PASS_THROUGH 3
`define CFG_BIT_OSC_FALLBACK 1

// Mode select field positions
`define CFG_BIT_FAILSAFE_LOW 7
`define CFG_BIT_CRC_ERR_CLEAR 5

// Sync filter: pulses shorter than this many clocks are rejected
`define CFG_FILTER_CYCLES 2

`endif

// [hw/serializer_cfg_pkg.sv]
package serializer_cfg_pkg;

    typedef struct packed {
        logic video_active;
        logic line_sync;
        logic frame_sync;
    } sync_bundle_t;

    typedef struct packed {
        logic crc_check_enable;
        logic crc_counter_clear;
        logic filter_enable;
        logic oscillator_fallback_enable;
        logic failsafe_low;
    } core_ctrl_t;

    typedef struct packed {
        logic auto_ack;
        logic pass_through;
        logic pass_all;
    } i2c_port_ctrl_t;

endpackage

// [hw/sync_glitch_filter.sv]
`timescale 1ns/1ps
`include "serializer_cfg_params.svh"

module sync_glitch_filter #(
    parameter int HOLD_CYCLES = `CFG_FILTER_CYCLES
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic enable,
    input wire logic din,
    output logic dout
);

    logic meta_reg;
    logic sync_reg;
    logic [7:0] run_reg;
    logic [7:0] run_next;
    logic out_reg;
    logic out_next;
    wire logic differs;

    assign differs = sync_reg != out_reg;
    assign run_next = differs ? 8'(run_reg + 8'h01) : 8'h00;
    // When enabled, accept a new level only once it has held the full filter span; when disabled, pass sync_reg straight through
    assign out_next = !enable ? sync_reg :
                      (differs && run_next >= 8'(HOLD_CYCLES)) ? sync_reg : out_reg;

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            meta_reg <= 1'b0;
            sync_reg <= 1'b0;
            run_reg <= 8'h00;
            out_reg <= 1'b0;
        end
        else
        begin
            meta_reg <= din;
            sync_reg <= meta_reg;
            run_reg <= (out_next != out_reg) ? 8'h00 : run_next;
            out_reg <= out_next;
        end
    end

    assign dout = out_reg;

endmodule

// [hw/serializer_general_config_regs.sv]
// Behaviour
// - Bit 7 enables back-channel CRC checker.
// - Auto-acknowledge remote deserializer writes immediately.
// - With pass-all, auto-ack covers every remote slave.
// - Auto-ack suppresses remote NACK towards master.
// - Filter drops sync pulses under two clocks.
// - Pass-through forwards alias-matching I2C transactions.
// - Second-port select steers auto-ack, pass-through.
// - Fallback to oscillator when TMDS clock absent.
// - Failsafe bit: zero high, one low.
// - CRC clear bit holds counters cleared.
`timescale 1ns/1ps
`include "serializer_cfg_params.svh"

module serializer_general_config_regs (
    input wire logic clk,
    input wire logic rst,
    // Register access from the serial control bus engine
    input wire logic reg_write,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    // Port selection and pass-all from elsewhere in the bank
    input wire logic second_port_select,
    input wire logic i2c_pass_all,
    // I2C forwarding engine handshake
    input wire logic remote_write_pending,
    input wire logic remote_target_is_deser,
    input wire logic remote_nack,
    input wire logic alias_match,
    output logic local_ack,
    output logic forward_to_remote,
    output logic relay_nack,
    // Clock source
    input wire logic tmds_clock_present,
    output logic use_internal_osc,
    // Video sync inputs
    input wire logic video_active_input,
    input wire logic line_sync_input,
    input wire logic frame_sync_input,
    output serializer_cfg_pkg::sync_bundle_t sync_filtered,
    // Control to the core
    output serializer_cfg_pkg::core_ctrl_t core_ctrl,
    output serializer_cfg_pkg::i2c_port_ctrl_t port0_ctrl,
    output serializer_cfg_pkg::i2c_port_ctrl_t port1_ctrl
);

    // ----------------------------------------
    // Register storage
    // ----------------------------------------
    logic [7:0] general_configuration_reg;
    logic [7:0] mode_select_reg;
    logic port1_auto_ack_reg;
    logic port1_pass_through_reg;
    logic [7:0] general_configuration_next;
    logic [7:0] mode_select_next;
    logic port1_auto_ack_next;
    logic port1_pass_through_next;
    logic [7:0] rdata_reg;

    wire logic hit_general;
    wire logic hit_mode;
    wire logic [7:0] general_view;
    wire logic [7:0] wr_general;

    function automatic logic [7:0] masked_merge(input logic [7:0] old_val, input logic [7:0] new_val,
                                                input logic [7:0] mask);
        masked_merge = (old_val & ~mask) | (new_val & mask);
    endfunction

    assign hit_general = reg_write && reg_addr == `CFG_ADDR_GENERAL;
    assign hit_mode = reg_write && reg_addr == `CFG_ADDR_MODE;

    // Port-specific bits live in a per-port copy selected by second_port_select
    assign general_view = second_port_select ?
        {general_configuration_reg[7:6], port1_auto_ack_reg, general_configuration_reg[4],
         port1_pass_through_reg, general_configuration_reg[2:0]} : general_configuration_reg;
    assign wr_general = masked_merge(general_view, reg_wdata, `CFG_GENERAL_MASK);

    always_comb
    begin
        general_configuration_next = general_configuration_reg;
        port1_auto_ack_next = port1_auto_ack_reg;
        port1_pass_through_next = port1_pass_through_reg;
        if (hit_general)
        begin
            general_configuration_next[7] = wr_general[7];
            general_configuration_next[4] = wr_general[4];
            general_configuration_next[1] = wr_general[1];
            if (second_port_select)
            begin
                port1_auto_ack_next = wr_general[`CFG_BIT_AUTO_ACK];
                port1_pass_through_next = wr_general[`CFG_BIT_PASS_THROUGH];
            end
            else
            begin
                general_configuration_next[5] = wr_general[5];
                general_configuration_next[3] = wr_general[3];
            end
        end
    end

    // Clear bit is never self-cleared; only software writes change it
    assign mode_select_next = hit_mode ? masked_merge(mode_select_reg, reg_wdata, `CFG_MODE_MASK)
                                       : mode_select_reg;

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            general_configuration_reg <= `CFG_GENERAL_RESET;
        else
            general_configuration_reg <= general_configuration_next;
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            mode_select_reg <= `CFG_MODE_RESET;
        else
            mode_select_reg <= mode_select_next;
    end

    // Second-port copies of auto-ack and pass-through, both off after reset
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            port1_auto_ack_reg <= 1'b0;
            port1_pass_through_reg <= 1'b0;
        end
        else
        begin
            port1_auto_ack_reg <= port1_auto_ack_next;
            port1_pass_through_reg <= port1_pass_through_next;
        end
    end

    // ----------------------------------------
    // Read path
    // ----------------------------------------
    wire logic [7:0] rdata_next;

    assign rdata_next = (reg_addr == `CFG_ADDR_GENERAL) ? (general_view & `CFG_GENERAL_MASK) :
                        (reg_addr == `CFG_ADDR_MODE) ? (mode_select_reg & `CFG_MODE_MASK) :
                        8'h00;

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            rdata_reg <= 8'h00;
        else
            rdata_reg <= rdata_next;
    end

    assign reg_rdata = rdata_reg;

    // ----------------------------------------
    // I2C path decisions
    // ----------------------------------------
    wire logic cur_auto_ack;
    wire logic cur_pass_through;
    wire logic ack_eligible;
    wire logic local_ack_next;
    wire logic forward_next;
    wire logic relay_nack_next;
    serializer_cfg_pkg::i2c_port_ctrl_t port0_next;
    serializer_cfg_pkg::i2c_port_ctrl_t port1_next;
    logic local_ack_reg;
    logic forward_reg;
    logic relay_nack_reg;
    serializer_cfg_pkg::i2c_port_ctrl_t port0_reg;
    serializer_cfg_pkg::i2c_port_ctrl_t port1_reg;

    assign cur_auto_ack = second_port_select ? port1_auto_ack_reg
                                             : general_configuration_reg[`CFG_BIT_AUTO_ACK];
    assign cur_pass_through = second_port_select ? port1_pass_through_reg
                                                 : general_configuration_reg[`CFG_BIT_PASS_THROUGH];
    assign ack_eligible = remote_target_is_deser || i2c_pass_all;
    assign local_ack_next = remote_write_pending && cur_auto_ack && ack_eligible;
    assign forward_next = alias_match && cur_pass_through;
    // Master was already answered, so a late remote NACK is swallowed
    assign relay_nack_next = remote_nack && !cur_auto_ack;
    assign port0_next = '{auto_ack: general_configuration_reg[`CFG_BIT_AUTO_ACK],
                          pass_through: general_configuration_reg[`CFG_BIT_PASS_THROUGH],
                          pass_all: i2c_pass_all};
    assign port1_next = '{auto_ack: port1_auto_ack_reg, pass_through: port1_pass_through_reg,
                          pass_all: i2c_pass_all};

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            local_ack_reg <= 1'b0;
            forward_reg <= 1'b0;
            relay_nack_reg <= 1'b0;
        end
        else
        begin
            local_ack_reg <= local_ack_next;
            forward_reg <= forward_next;
            relay_nack_reg <= relay_nack_next;
        end
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            port0_reg <= '0;
            port1_reg <= '0;
        end
        else
        begin
            port0_reg <= port0_next;
            port1_reg <= port1_next;
        end
    end

    assign local_ack = local_ack_reg;
    assign forward_to_remote = forward_reg;
    assign relay_nack = relay_nack_reg;
    assign port0_ctrl = port0_reg;
    assign port1_ctrl = port1_reg;

    // ----------------------------------------
    // Clock source and core control
    // ----------------------------------------
    logic clk_meta_reg;
    logic clk_sync_reg;
    logic osc_reg;
    wire logic osc_next;
    serializer_cfg_pkg::core_ctrl_t core_reg;
    serializer_cfg_pkg::core_ctrl_t core_next;

    assign osc_next = general_configuration_reg[`CFG_BIT_OSC_FALLBACK] && !clk_sync_reg;
    assign core_next = '{crc_check_enable: general_configuration_reg[`CFG_BIT_CRC_CHECK],
                         crc_counter_clear: mode_select_reg[`CFG_BIT_CRC_ERR_CLEAR],
                         filter_enable: general_configuration_reg[`CFG_BIT_FILTER],
                         oscillator_fallback_enable: general_configuration_reg[`CFG_BIT_OSC_FALLBACK],
                         failsafe_low: mode_select_reg[`CFG_BIT_FAILSAFE_LOW]};

    // Presence starts as seen, so leaving reset does not flick to the oscillator
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            clk_meta_reg <= 1'b1;
            clk_sync_reg <= 1'b1;
        end
        else
        begin
            clk_meta_reg <= tmds_clock_present;
            clk_sync_reg <= clk_meta_reg;
        end
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            osc_reg <= 1'b0;
            core_reg <= '0;
        end
        else
        begin
            osc_reg <= osc_next;
            core_reg <= core_next;
        end
    end

    assign use_internal_osc = osc_reg;
    assign core_ctrl = core_reg;

    // ----------------------------------------
    // Sync input filters
    // ----------------------------------------
    logic de_f;
    logic hs_f;
    logic vs_f;
    wire logic filt_en;

    assign filt_en = general_configuration_reg[`CFG_BIT_FILTER];

    sync_glitch_filter #(.HOLD_CYCLES(`CFG_FILTER_CYCLES)) u_de_filter (
        .clk(clk),
        .rst(rst),
        .enable(filt_en),
        .din(video_active_input),
        .dout(de_f)
    );

    sync_glitch_filter #(.HOLD_CYCLES(`CFG_FILTER_CYCLES)) u_hs_filter (
        .clk(clk),
        .rst(rst),
        .enable(filt_en),
        .din(line_sync_input),
        .dout(hs_f)
    );

    sync_glitch_filter #(.HOLD_CYCLES(`CFG_FILTER_CYCLES)) u_vs_filter (
        .clk(clk),
        .rst(rst),
        .enable(filt_en),
        .din(frame_sync_input),
        .dout(vs_f)
    );

    assign sync_filtered = '{video_active: de_f, line_sync: hs_f, frame_sync: vs_f};

endmodule

// [bench/cfg_regs_monitor.sv]
`timescale 1ns/1ps
module cfg_regs_monitor (
    input wire logic clk,
    input wire logic rst,
    input wire logic reg_write,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic [7:0] reg_rdata,
    input wire logic second_port_select,
    input wire logic i2c_pass_all,
    input wire logic remote_write_pending,
    input wire logic remote_target_is_deser,
    input wire logic remote_nack,
    input wire logic alias_match,
    input wire logic local_ack,
    input wire logic forward_to_remote,
    input wire logic relay_nack,
    input wire logic tmds_clock_present,
    input wire logic use_internal_osc,
    input wire serializer_cfg_pkg::core_ctrl_t core_ctrl,
    input wire serializer_cfg_pkg::i2c_port_ctrl_t port0_ctrl
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    a_gen_write: assert property ((reg_write && reg_addr == 8'h03) ##1 !reg_write |-> ##1
        core_ctrl.crc_check_enable == $past(reg_wdata[7], 2) && core_ctrl.filter_enable == $past(reg_wdata[4], 2)
        && core_ctrl.oscillator_fallback_enable == $past(reg_wdata[1], 2)) else $error("general write lost");
    a_mode_write: assert property ((reg_write && reg_addr == 8'h04) ##1 !reg_write |-> ##1
        core_ctrl.failsafe_low == $past(reg_wdata[7], 2) && core_ctrl.crc_counter_clear == $past(reg_wdata[5], 2))
        else $error("mode write lost");
    a_ack_cause: assert property (local_ack |-> $past(remote_write_pending) &&
        ($past(remote_target_is_deser) || $past(i2c_pass_all))) else $error("ack without cause");
    a_nack_block: assert property ((port0_ctrl.auto_ack && !second_port_select)[*3] |-> !relay_nack)
        else $error("nack relayed under auto ack");
    a_nack_cause: assert property (relay_nack |-> $past(remote_nack)) else $error("nack without cause");
    a_fwd_cause: assert property (forward_to_remote |-> $past(alias_match)) else $error("forward no match");
    a_osc_on: assert property ((!tmds_clock_present && core_ctrl.oscillator_fallback_enable)[*5]
        |-> use_internal_osc) else $error("no fallback");
    a_osc_off: assert property ((tmds_clock_present || !core_ctrl.oscillator_fallback_enable)[*5]
        |-> !use_internal_osc) else $error("spurious fallback");
    a_rsvd_zero: assert property (!(($past(reg_addr) == 8'h03 && (reg_rdata & 8'h45) != 8'h00) ||
        ($past(reg_addr) == 8'h04 && (reg_rdata & 8'h5F) != 8'h00))) else $error("reserved bit set");
    cover property (local_ack);
    cover property (forward_to_remote);
    cover property (use_internal_osc);
endmodule

bind serializer_general_config_regs cfg_regs_monitor u_mon (.clk(clk), .rst(rst), .reg_write(reg_write),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .second_port_select(second_port_select),
    .i2c_pass_all(i2c_pass_all), .remote_write_pending(remote_write_pending), .remote_nack(remote_nack),
    .remote_target_is_deser(remote_target_is_deser), .alias_match(alias_match), .local_ack(local_ack),
    .forward_to_remote(forward_to_remote), .relay_nack(relay_nack), .tmds_clock_present(tmds_clock_present),
    .use_internal_osc(use_internal_osc), .core_ctrl(core_ctrl), .port0_ctrl(port0_ctrl));

// [bench/host_master_model.sv]
`timescale 1ns/1ps
module host_master_model (
    input wire logic clk,
    output logic reg_write,
    output logic [7:0] reg_addr,
    output logic [7:0] reg_wdata
);
    initial
    begin
        reg_write = 1'b0;
        reg_addr = 8'hFF;
        reg_wdata = 8'h00;
    end
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk);
        reg_write = 1'b1;
        reg_addr = a;
        reg_wdata = d;
        @(negedge clk);
        reg_write = 1'b0;
        // Released data shows inverse
        reg_wdata = ~d;
    endtask
    task automatic rd(input logic [7:0] a);
        @(negedge clk);
        reg_addr = a;
    endtask
endmodule

// [bench/testbench.sv]
`timescale 1ns/1ps
module testbench;
    logic clk, rst, sel, pa, pend, deser, nack, alias_m, tmds, reg_write;
    logic local_ack, forward_to_remote, relay_nack, use_internal_osc;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, d;
    logic [2:0] sync_in;
    logic [31:0] r;
    logic [10:0] nt;
    logic [10:0] notes[$];
    serializer_cfg_pkg::sync_bundle_t sync_filtered;
    serializer_cfg_pkg::core_ctrl_t core_ctrl;
    serializer_cfg_pkg::i2c_port_ctrl_t port0_ctrl, port1_ctrl;
    int num_errors = 0, n_checks = 0, cycles = 0, seed, i;
    string names[6] = '{"rdata", "core_ctrl", "port_ctrl", "i2c_out", "sync", "osc"};

    host_master_model u_host (.clk(clk), .reg_write(reg_write), .reg_addr(reg_addr), .reg_wdata(reg_wdata));
    serializer_general_config_regs u_dut (.clk(clk), .rst(rst), .reg_write(reg_write), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .second_port_select(sel), .i2c_pass_all(pa),
        .remote_write_pending(pend), .remote_target_is_deser(deser), .remote_nack(nack), .alias_match(alias_m),
        .local_ack(local_ack), .forward_to_remote(forward_to_remote), .relay_nack(relay_nack),
        .tmds_clock_present(tmds), .use_internal_osc(use_internal_osc), .video_active_input(sync_in[2]),
        .line_sync_input(sync_in[1]), .frame_sync_input(sync_in[0]), .sync_filtered(sync_filtered),
        .core_ctrl(core_ctrl), .port0_ctrl(port0_ctrl), .port1_ctrl(port1_ctrl));

    initial
    begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    // ----------------------------------------
    // Scoreboard
    // ----------------------------------------
    function automatic logic [7:0] obs(input logic [2:0] k);
        case (k)
            3'd0: return reg_rdata;
            3'd1: return {3'b000, core_ctrl};
            3'd2: return {2'b00, port0_ctrl, port1_ctrl};
            3'd3: return {5'b00000, local_ack, forward_to_remote, relay_nack};
            3'd4: return {5'b00000, sync_filtered};
            default: return {7'b0000000, use_internal_osc};
        endcase
    endfunction
    task automatic check(input string nm, input logic [7:0] seen, input logic [7:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("wrong value %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic note(input logic [2:0] k, input logic [7:0] v);
        notes.push_back({k, v});
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        u_host.rd(a);
        @(negedge clk);
        note(3'd0, e);
    endtask
    always @(negedge clk)
    begin
        #1;
        while (notes.size() > 0)
        begin
            nt = notes.pop_front();
            check(names[nt[10:8]], obs(nt[10:8]), nt[7:0]);
        end
    end
    task automatic summarize;
        $display("checks %0d mismatches %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 3000)
        begin
            num_errors++;
            summarize();
        end
    end

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial
    begin
        seed = 74;
        {rst, sel, pa, pend, deser, nack, alias_m, tmds, sync_in} = {1'b1, 6'h00, 1'b1, 3'b000};
        repeat (3) @(negedge clk);
        rst = 1'b0;
        rd(8'h03, 8'h92);
        rd(8'h04, 8'h80);
        note(3'd1, 8'h17);
        $display("reset test done");
        for (i = 0; i < 4; i++)
        begin
            d = $random(seed);
            u_host.wr(8'h03, d);
            rd(8'h03, d & 8'hBA);
            note(3'd1, {3'b000, d[7], 1'b0, d[4], d[1], 1'b1});
        end
        u_host.wr(8'h05, 8'hFF);
        rd(8'h05, 8'h00);
        u_host.wr(8'h04, 8'hFF);
        rd(8'h04, 8'hA0);
        repeat (20) @(negedge clk);
        note(3'd1, {3'b000, d[7], 1'b1, d[4], d[1], 1'b1});
        u_host.wr(8'h04, 8'h00);
        rd(8'h04, 8'h00);
        note(3'd1, {3'b000, d[7], 1'b0, d[4], d[1], 1'b0});
        $display("register test done");
        u_host.wr(8'h03, 8'h12);
        sel = 1'b1;
        u_host.wr(8'h03, 8'h3A);
        rd(8'h03, 8'h3A);
        note(3'd2, 8'h06);
        pa = 1'b1;
        @(negedge clk);
        note(3'd2, 8'h0F);
        pa = 1'b0;
        sel = 1'b0;
        rd(8'h03, 8'h12);
        for (i = 0; i < 24; i++)
        begin
            r = $random(seed);
            {sel, pa, pend, deser, nack, alias_m} = r[5:0];
            @(negedge clk);
            note(3'd3, {5'b00000, pend && sel && (deser || pa), alias_m && sel, nack && !sel});
        end
        {sel, pa, pend, deser, nack, alias_m} = 6'h00;
        $display("i2c test done");
        tmds = 1'b0;
        repeat (4) @(negedge clk);
        note(3'd5, 8'h01);
        u_host.wr(8'h03, 8'h10);
        repeat (4) @(negedge clk);
        note(3'd5, 8'h00);
        tmds = 1'b1;
        $display("clock test done");
        sync_in = 3'b111;
        @(negedge clk);
        sync_in = 3'b000;
        repeat (6)
        begin
            @(negedge clk);
            note(3'd4, 8'h00);
        end
        sync_in = 3'b111;
        repeat (5) @(negedge clk);
        note(3'd4, 8'h07);
        sync_in = 3'b000;
        u_host.wr(8'h03, 8'h00);
        repeat (6) @(negedge clk);
        sync_in = 3'b101;
        @(negedge clk);
        sync_in = 3'b000;
        repeat (2) @(negedge clk);
        note(3'd4, 8'h05);
        $display("filter test done");
        repeat (3) @(negedge clk);
        summarize();
    end
endmodule
